// File: logic/soe_addr_form.sv
/*
  Execution address adder for the eight address modes.
  Assumes base is the displacement, or the indirect word once it was read.
*/
`timescale 1ns/10ps
`default_nettype none
`include "soe_params.svh"

module soe_addr_form (
  // selection
  input  wire logic [2:0]              mode,
  // sources
  input  wire logic [0:`SOE_WORD_W-1] base,
  input  wire logic [0:`SOE_WORD_W-1] progAddr,
  input  wire logic [0:`SOE_WORD_W-1] indexB1,
  input  wire logic [0:`SOE_WORD_W-1] indexB2,
  // result
  output logic      [0:`SOE_WORD_W-1] execAddr
);

  // modes 0-2 and 4-6 share one adder: only the base differs
  always_comb begin
    unique case (mode)
      3'h1, 3'h5: execAddr = base + indexB1;
      3'h2, 3'h6: execAddr = base + indexB2;
      3'h3:       execAddr = progAddr + base;
      3'h7:       execAddr = progAddr - base;
      default:    execAddr = base;
    endcase
  end

endmodule : soe_addr_form

`default_nettype wire

// File: logic/soe_alu.sv
/*
  Combinational datapath: adder with forced carry, logic gates and byte
  shift network. Assumes acc and operand are stable registers.
*/
`timescale 1ns/10ps
`default_nettype none
`include "soe_params.svh"

module soe_alu (
  // selection
  input  wire soe_pkg::soe_func_t      func,
  // operands
  input  wire logic [0:`SOE_WORD_W-1] acc,
  input  wire logic [0:`SOE_WORD_W-1] opnd,
  // results
  output logic      [0:`SOE_WORD_W-1] result,
  output logic                        carryOut
);

  logic [`SOE_WORD_W:0]   sumWide;
  logic [0:`SOE_WORD_W-1] adderA;
  logic [0:`SOE_WORD_W-1] adderB;
  logic                   forceCarry;

  always_comb begin
    adderA     = acc;
    adderB     = opnd;
    forceCarry = 1'b0;
    result     = acc;
    unique case (func)
      soe_pkg::FN_LOAD_RIGHT:  result = {{`SOE_BYTE_W{1'b0}}, opnd[`SOE_RIGHT_BYTE]};
      soe_pkg::FN_SUB: begin
        adderB     = ~opnd;
        forceCarry = 1'b1;
      end
      soe_pkg::FN_REP_ADD_ONE: begin
        adderA     = '0;
        forceCarry = 1'b1;
      end
      soe_pkg::FN_XOR:         result = acc ^ opnd;
      soe_pkg::FN_AND:         result = acc & opnd;
      // left-byte replace: right byte of acc goes to the left, right byte of the operand to the right
      soe_pkg::FN_REP_LEFT:    result = {acc[`SOE_RIGHT_BYTE], opnd[`SOE_RIGHT_BYTE]};
      soe_pkg::FN_REP_RIGHT:   result = {opnd[`SOE_LEFT_BYTE], acc[`SOE_RIGHT_BYTE]};
      soe_pkg::FN_LOAD_OPND:   result = opnd;
      default: ;
    endcase
    sumWide  = {1'b0, adderA} + {1'b0, adderB} + {{`SOE_WORD_W{1'b0}}, forceCarry};
    carryOut = sumWide[`SOE_WORD_W];
    if (func == soe_pkg::FN_ADD || func == soe_pkg::FN_SUB || func == soe_pkg::FN_REP_ADD_ONE) begin
      result = sumWide[`SOE_WORD_W-1:0];
    end
  end

endmodule : soe_alu

`default_nettype wire

// File: logic/soe_exec_unit.sv
/*
  Operand execute unit: instruction fetch, address formation, operand read
  and store cycles driven by one timing chain, with accumulator and adder
  status. Assumes a memory on mclk that answers each request with memAck.
*/
`timescale 1ns/10ps
`default_nettype none
`include "soe_params.svh"

module soe_exec_unit #(
  parameter int unsigned CHAIN_LEN = `SOE_CHAIN_LEN
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  // index registers from the surrounding processor
  input  wire logic [0:`SOE_WORD_W-1] indexB1,
  input  wire logic [0:`SOE_WORD_W-1] indexB2,
  // memory port
  output logic                        memReq,
  output logic                        memWrite,
  output logic      [0:`SOE_WORD_W-1] memAddr,
  output logic      [0:`SOE_WORD_W-1] memWdata,
  input  wire logic                   memAck,
  input  wire logic [0:`SOE_WORD_W-1] memRdata,
  // state and strobes
  output logic      [0:`SOE_WORD_W-1] accumulator,
  output logic      [0:`SOE_WORD_W-1] progAddr,
  output logic                        adderStatusFlipflop,
  output logic                        accumulatorLoadStrobe,
  output logic                        addressRegisterLoadStrobe,
  output logic                        jumpTaken,
  output var soe_pkg::soe_cycle_t     cycleState,
  output logic                        phaseT00
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    soe_pkg::soe_cycle_t    cyc;
    logic [3:0]             phase;
    logic [0:`SOE_WORD_W-1] instr;
    logic [0:`SOE_WORD_W-1] indWord;
    logic [0:`SOE_WORD_W-1] opnd;
    logic [0:`SOE_WORD_W-1] acc;
    logic [0:`SOE_WORD_W-1] sAddr;
    logic [0:`SOE_WORD_W-1] pAddr;
    logic [0:`SOE_WORD_W-1] wdata;
    logic                   adderStatus;
    logic                   accStrobe;
    logic                   sStrobe;
    logic                   jump;
  } soe_state_t;

  soe_state_t st;
  soe_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic [3:0]             opGroup;
  logic                   opHalf;
  logic [2:0]             opMode;
  logic                   isLoadRight;
  logic                   isAdd;
  logic                   isSub;
  logic                   isRepAdd;
  logic                   isRepAddOne;
  logic                   isStore;
  logic                   isStoreZero;
  logic                   isDestLoad;
  logic                   isJump;
  logic                   operandGroupDecode;
  logic                   readModifyWriteGroupDecode;
  logic                   needsRead;
  logic                   supported;
  logic                   jumpAddressCycleEnable;
  logic                   zeroWriteSelect;
  logic                   adderGroup;
  soe_pkg::soe_func_t     func;

  assign opGroup     = st.instr[0:3];
  assign opHalf      = st.instr[4];
  assign opMode      = st.instr[5:7];
  assign isLoadRight = opGroup == `SOE_GRP_BYTE && opHalf;
  assign isAdd       = opGroup == `SOE_GRP_ADDSUB && !opHalf;
  assign isSub       = opGroup == `SOE_GRP_ADDSUB && opHalf;
  assign isRepAdd    = opGroup == `SOE_GRP_REPADD && !opHalf;
  assign isRepAddOne = opGroup == `SOE_GRP_REPADD && opHalf;
  assign isStore     = opGroup == `SOE_GRP_STORE && !opHalf;
  assign isStoreZero = opGroup == `SOE_GRP_STORE && opHalf;
  assign isDestLoad  = opGroup == `SOE_GRP_DLDJMP && !opHalf;
  assign isJump      = opGroup == `SOE_GRP_DLDJMP && opHalf;

  assign operandGroupDecode = isLoadRight || opGroup == `SOE_GRP_ADDSUB || opGroup == `SOE_GRP_LOGIC;
  assign readModifyWriteGroupDecode = opGroup == `SOE_GRP_REPADD || opGroup == `SOE_GRP_REPBYTE
                                      || isDestLoad;
  assign needsRead  = operandGroupDecode || readModifyWriteGroupDecode;
  assign supported  = needsRead || isStore || isStoreZero || isJump;
  assign adderGroup = isAdd || isSub || isRepAdd || isRepAddOne;
  assign zeroWriteSelect = isStoreZero || isDestLoad;

  // indirect modes need the extra address formation read
  assign jumpAddressCycleEnable = opMode == `SOE_MODE_IND || opMode == `SOE_MODE_IND_B1
                                  || opMode == `SOE_MODE_IND_B2;

  always_comb begin
    func = soe_pkg::FN_PASS_ACC;
    if (isLoadRight) begin
      func = soe_pkg::FN_LOAD_RIGHT;
    end else if (isAdd || isRepAdd) begin
      func = soe_pkg::FN_ADD;
    end else if (isSub) begin
      func = soe_pkg::FN_SUB;
    end else if (opGroup == `SOE_GRP_LOGIC) begin
      func = opHalf ? soe_pkg::FN_AND : soe_pkg::FN_XOR;
    end else if (isRepAddOne) begin
      func = soe_pkg::FN_REP_ADD_ONE;
    end else if (opGroup == `SOE_GRP_REPBYTE) begin
      func = opHalf ? soe_pkg::FN_REP_RIGHT : soe_pkg::FN_REP_LEFT;
    end else if (isDestLoad) begin
      func = soe_pkg::FN_LOAD_OPND;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath

  logic [0:`SOE_WORD_W-1] aluResult;
  logic                   aluCarry;
  logic [0:`SOE_WORD_W-1] addrBase;
  logic [0:`SOE_WORD_W-1] execAddr;
  logic [0:`SOE_WORD_W-1] nextInstrAddr;

  soe_alu u_alu (
    .func     (func),
    .acc      (st.acc),
    .opnd     (st.opnd),
    .result   (aluResult),
    .carryOut (aluCarry)
  );

  // displacement in the first pass, the word read from memory after it
  assign addrBase = (st.cyc == soe_pkg::CYC_ADDR_FORM) ? st.indWord
                    : {{`SOE_BYTE_W{1'b0}}, st.instr[`SOE_RIGHT_BYTE]};

  soe_addr_form u_addr_form (
    .mode     (opMode),
    .base     (addrBase),
    .progAddr (st.pAddr),
    .indexB1  (indexB1),
    .indexB2  (indexB2),
    .execAddr (execAddr)
  );

  assign nextInstrAddr = st.pAddr + 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // timing chain and cycle sequencing

  logic atT00;
  logic reqPhase;

  assign atT00    = st.phase == `SOE_PHASE_T00;
  assign reqPhase = st.phase == `SOE_PHASE_REQ;

  always_comb begin
    next_st           = st;
    next_st.accStrobe = 1'b0;
    next_st.sStrobe   = 1'b0;
    next_st.jump      = 1'b0;

    // chain holds in the request phase until memory answers
    if (reqPhase) begin
      if (memAck) begin
        next_st.phase = (CHAIN_LEN > 2) ? `SOE_PHASE_REQ + 4'h1 : `SOE_PHASE_T00;
        unique case (st.cyc)
          soe_pkg::CYC_NEXT_INSTR:   next_st.instr   = memRdata;
          soe_pkg::CYC_ADDR_FORM:    next_st.indWord = memRdata;
          soe_pkg::CYC_OPERAND_READ: next_st.opnd    = memRdata;
          soe_pkg::CYC_MEM_WRITE:    ;
        endcase
      end
    end else if (atT00) begin
      next_st.phase = `SOE_PHASE_REQ;
    end else if (st.phase == 4'(CHAIN_LEN - 1)) begin
      next_st.phase = `SOE_PHASE_T00;
    end else begin
      next_st.phase = st.phase + 4'h1;
    end

    if (atT00) begin
      unique case (st.cyc)
        soe_pkg::CYC_NEXT_INSTR, soe_pkg::CYC_ADDR_FORM: begin
          if (!supported) begin
            next_st.pAddr   = nextInstrAddr;
            next_st.sAddr   = nextInstrAddr;
            next_st.sStrobe = 1'b1;
            next_st.cyc     = soe_pkg::CYC_NEXT_INSTR;
          end else if (st.cyc == soe_pkg::CYC_NEXT_INSTR && jumpAddressCycleEnable) begin
            next_st.sAddr   = addrBase;
            next_st.sStrobe = 1'b1;
            next_st.cyc     = soe_pkg::CYC_ADDR_FORM;
          end else if (isJump) begin
            next_st.sAddr   = execAddr;
            next_st.pAddr   = execAddr;
            next_st.sStrobe = 1'b1;
            next_st.jump    = 1'b1;
            next_st.cyc     = soe_pkg::CYC_NEXT_INSTR;
          end else if (needsRead) begin
            next_st.sAddr   = execAddr;
            next_st.sStrobe = 1'b1;
            next_st.cyc     = soe_pkg::CYC_OPERAND_READ;
          end else begin
            next_st.sAddr   = execAddr;
            next_st.sStrobe = 1'b1;
            next_st.wdata   = zeroWriteSelect ? '0 : st.acc;
            next_st.cyc     = soe_pkg::CYC_MEM_WRITE;
          end
        end
        soe_pkg::CYC_OPERAND_READ: begin
          next_st.acc       = aluResult;
          next_st.accStrobe = 1'b1;
          if (adderGroup) begin
            next_st.adderStatus = aluCarry;
          end
          if (readModifyWriteGroupDecode) begin
            // address register left alone so the store hits the operand word
            next_st.wdata = zeroWriteSelect ? '0 : aluResult;
            next_st.cyc   = soe_pkg::CYC_MEM_WRITE;
          end else begin
            next_st.pAddr   = nextInstrAddr;
            next_st.sAddr   = nextInstrAddr;
            next_st.sStrobe = 1'b1;
            next_st.cyc     = soe_pkg::CYC_NEXT_INSTR;
          end
        end
        soe_pkg::CYC_MEM_WRITE: begin
          next_st.pAddr   = nextInstrAddr;
          next_st.sAddr   = nextInstrAddr;
          next_st.sStrobe = 1'b1;
          next_st.cyc     = soe_pkg::CYC_NEXT_INSTR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st             <= '0;
      st.cyc         <= soe_pkg::CYC_NEXT_INSTR;
      st.phase       <= `SOE_PHASE_REQ;
      st.acc         <= `SOE_ACC_RST;
      st.sAddr       <= `SOE_ADDR_RST;
      st.pAddr       <= `SOE_ADDR_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign memReq                    = reqPhase;
  assign memWrite                  = st.cyc == soe_pkg::CYC_MEM_WRITE;
  assign memAddr                   = st.sAddr;
  assign memWdata                  = st.wdata;
  assign accumulator               = st.acc;
  assign progAddr                  = st.pAddr;
  assign adderStatusFlipflop       = st.adderStatus;
  assign accumulatorLoadStrobe     = st.accStrobe;
  assign addressRegisterLoadStrobe = st.sStrobe;
  assign jumpTaken                 = st.jump;
  assign cycleState                = st.cyc;
  assign phaseT00                  = atT00;

endmodule : soe_exec_unit

`default_nettype wire

// File: logic/soe_params.svh
/*
  Constants of the operand execute unit: word layout, opcode groups,
  address modes, timing chain length and reset values.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef SOE_PARAMS_SVH
`define SOE_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// word layout, bit 0 is the most significant bit
`define SOE_WORD_W        16
`define SOE_BYTE_W        8
`define SOE_LEFT_BYTE     0:7
`define SOE_RIGHT_BYTE    8:15

////////////////////////////////////////////////////////////////////////////////
// opcode groups, first hex digit of the instruction word
`define SOE_GRP_BYTE      4'h5
`define SOE_GRP_ADDSUB    4'h6
`define SOE_GRP_LOGIC     4'h7
`define SOE_GRP_REPADD    4'h8
`define SOE_GRP_REPBYTE   4'h9
`define SOE_GRP_STORE     4'hA
`define SOE_GRP_DLDJMP    4'hB

////////////////////////////////////////////////////////////////////////////////
// address modes, low three bits of the second hex digit
`define SOE_MODE_IND      3'h4
`define SOE_MODE_IND_B1   3'h5
`define SOE_MODE_IND_B2   3'h6

////////////////////////////////////////////////////////////////////////////////
// timing chain and reset values
`define SOE_CHAIN_LEN     10
`define SOE_PHASE_T00     4'h0
`define SOE_PHASE_REQ     4'h1
`define SOE_ACC_RST       16'h0000
`define SOE_ADDR_RST      16'h0000

`endif

// File: logic/soe_pkg.sv
/*
  Types of the operand execute unit: machine cycles and datapath functions.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package soe_pkg;

  // machine cycle in progress
  typedef enum logic [1:0] {
    CYC_NEXT_INSTR,
    CYC_ADDR_FORM,
    CYC_OPERAND_READ,
    CYC_MEM_WRITE
  } soe_cycle_t;

  // function applied by the datapath in the operand read cycle
  typedef enum logic [3:0] {
    FN_PASS_ACC,
    FN_LOAD_RIGHT,
    FN_ADD,
    FN_SUB,
    FN_XOR,
    FN_AND,
    FN_REP_ADD_ONE,
    FN_REP_LEFT,
    FN_REP_RIGHT,
    FN_LOAD_OPND
  } soe_func_t;

endpackage : soe_pkg

`default_nettype wire

// File: tb/soe_exec_unit_assertions.sv
/*
  Checker of the operand execute unit, bound to the unit's ports.
  Assumes one clock, a synchronous reset and memory answers on memAck.
*/
`timescale 1ns/10ps
`default_nettype none
`include "soe_params.svh"

module soe_exec_unit_assertions #(
  parameter int unsigned CHAIN_LEN = `SOE_CHAIN_LEN
) (
  // clock and reset
  input wire logic                mclk,
  input wire logic                sys_rst,
  // index registers
  input wire logic [0:15]         indexB1,
  input wire logic [0:15]         indexB2,
  // memory port
  input wire logic                memReq,
  input wire logic                memWrite,
  input wire logic [0:15]         memAddr,
  input wire logic [0:15]         memWdata,
  input wire logic                memAck,
  input wire logic [0:15]         memRdata,
  // state and strobes
  input wire logic [0:15]         accumulator,
  input wire logic [0:15]         progAddr,
  input wire logic                adderStatusFlipflop,
  input wire logic                accumulatorLoadStrobe,
  input wire logic                addressRegisterLoadStrobe,
  input wire logic                jumpTaken,
  input wire soe_pkg::soe_cycle_t cycleState,
  input wire logic                phaseT00
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // instruction, operand and accumulator seen by the current instruction
  logic [0:15] instr, opnd, accOld;
  logic [3:0]  gap;
  logic [16:0] addS, subS;
  logic        zeroSel, jmpOp, rmwOp, carryExp, ldA;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      instr  <= 16'h0000;
      opnd   <= 16'h0000;
      accOld <= 16'h0000;
      gap    <= 4'h0;
    end else begin
      gap <= (memReq && memAck) ? 4'h1 : ((gap == 4'hF) ? gap : gap + 4'h1);
      if (memReq && memAck && cycleState == soe_pkg::CYC_NEXT_INSTR)
        instr <= memRdata;
      if (memReq && memAck && cycleState == soe_pkg::CYC_OPERAND_READ) begin
        opnd   <= memRdata;
        accOld <= accumulator;
      end
    end
  end

  assign addS     = {1'b0, accOld} + {1'b0, opnd};
  assign subS     = {1'b0, accOld} + {1'b0, ~opnd} + 17'h00001;
  assign zeroSel  = instr[0:4] == 5'b10101 || instr[0:4] == 5'b10110;
  assign jmpOp    = instr[0:4] == 5'b10111;
  assign rmwOp    = instr[0:3] == 4'h8 || instr[0:3] == 4'h9 || instr[0:4] == 5'b10110;
  assign carryExp = (instr[0:4] == 5'b01101) ? subS[16] :
                    (instr[0:4] == 5'b10001) ? (opnd == 16'hFFFF) : addS[16];
  assign ldA      = accumulatorLoadStrobe;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_read_end;
    cycleState == soe_pkg::CYC_OPERAND_READ && phaseT00;
  endsequence
  sequence s_ind_jump_form;
    cycleState == soe_pkg::CYC_ADDR_FORM && phaseT00 && jmpOp;
  endsequence

  acc_only_t00_a: assert property (!$stable(accumulator) |-> $past(phaseT00) && ldA)
    else $error("accumulator changed away from T00");
  chain_spacing_a: assert property ($rose(memReq) |-> gap == 4'(CHAIN_LEN))
    else $error("request spacing differs from chain length");
  load_right_a: assert property (ldA && instr[0:4] == 5'b01011 |-> accumulator == {8'h00, opnd[8:15]})
    else $error("right byte load wrong");
  add_sub_a: assert property (ldA && instr[0:3] == 4'h6 |->
    accumulator == (instr[4] ? subS[15:0] : addS[15:0])) else $error("add or subtract result wrong");
  status_carry_a: assert property (ldA && instr[0:3] inside {4'h6, 4'h8} |-> adderStatusFlipflop == carryExp)
    else $error("adder status wrong");
  logic_ops_a: assert property (ldA && instr[0:3] == 4'h7 |->
    accumulator == (instr[4] ? (accOld & opnd) : (accOld ^ opnd))) else $error("logic result wrong");
  replace_add_a: assert property (ldA && instr[0:3] == 4'h8 |->
    accumulator == (instr[4] ? opnd + 16'h0001 : addS[15:0])) else $error("replace add result wrong");
  replace_byte_a: assert property (ldA && instr[0:3] == 4'h9 |->
    accumulator == (instr[4] ? {opnd[0:7], accOld[8:15]} : {accOld[8:15], opnd[8:15]}))
    else $error("replace byte result wrong");
  dest_load_a: assert property (ldA && instr[0:4] == 5'b10110 |-> accumulator == opnd)
    else $error("destructive load result wrong");
  rmw_write_a: assert property (s_read_end ##0 rmwOp |=> cycleState == soe_pkg::CYC_MEM_WRITE && memWrite)
    else $error("no store after replace read");
  store_same_addr_a: assert property (cycleState == soe_pkg::CYC_MEM_WRITE &&
    $past(cycleState) == soe_pkg::CYC_OPERAND_READ |-> $stable(memAddr) && !addressRegisterLoadStrobe)
    else $error("store address moved after read");
  write_data_a: assert property (memReq && memWrite |-> memWdata == (zeroSel ? 16'h0000 : accumulator))
    else $error("write data wrong");
  jump_target_a: assert property (jumpTaken |-> jmpOp && progAddr == memAddr && addressRegisterLoadStrobe)
    else $error("jump target not loaded");
  ind_jump_a: assert property (s_ind_jump_form |=> jumpTaken)
    else $error("indirect jump not taken after formation");
endmodule : soe_exec_unit_assertions

bind soe_exec_unit soe_exec_unit_assertions #(.CHAIN_LEN(CHAIN_LEN)) chk_u (
  .mclk, .sys_rst, .indexB1, .indexB2, .memReq, .memWrite, .memAddr, .memWdata, .memAck, .memRdata,
  .accumulator, .progAddr, .adderStatusFlipflop, .accumulatorLoadStrobe, .addressRegisterLoadStrobe,
  .jumpTaken, .cycleState, .phaseT00
);

`default_nettype wire

// File: tb/soe_mem_model.sv
/*
  Behavioural processor memory: answers each request after zero or three
  wait cycles and takes stores. Assumes requests hold until acknowledged.
*/
`timescale 1ns/10ps
`default_nettype none

module soe_mem_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // pacing
  input  wire logic        slow,
  // memory port
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [0:15] memAddr,
  input  wire logic [0:15] memWdata,
  output logic             memAck,
  output logic      [0:15] memRdata
);
  logic [0:15] mem [0:255];
  logic [1:0]  waitCnt;

  // read data toggles between answers so no stale word looks valid
  always @(posedge mclk) begin
    memAck   <= 1'b0;
    memRdata <= sys_rst ? 16'hFFFF : ~memRdata;
    if (sys_rst) begin
      waitCnt <= 2'h0;
    end else if (memReq && memAck) begin
      waitCnt <= 2'h0;
      if (memWrite)
        mem[memAddr[8:15]] <= memWdata;
    end else if (memReq && (!slow || waitCnt == 2'h3)) begin
      memAck   <= 1'b1;
      memRdata <= mem[memAddr[8:15]];
    end else if (memReq) begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule : soe_mem_model

`default_nettype wire

// File: tb/tb_top.sv
/*
  Self-checking bench of the operand execute unit: runs a short program
  from the memory model and judges results and stores in order.
  Assumes the checker is attached by bind.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic                mclk, sys_rst, slow;
  logic                memReq, memWrite, memAck, adderStatusFlipflop, phaseT00;
  logic                accumulatorLoadStrobe, addressRegisterLoadStrobe, jumpTaken;
  logic [0:15]         indexB1, indexB2, memAddr, memWdata, memRdata, accumulator, progAddr;
  soe_pkg::soe_cycle_t cycleState;
  int                  n_errors, n_checks;
  // address byte, then word
  logic [0:23]         img [0:28] = '{
    24'h005810, 24'h016011, 24'h026812, 24'h037013, 24'h047814, 24'h058015, 24'h069017,
    24'h079818, 24'h088816, 24'h09B01A, 24'h0AA019, 24'h0BA81B, 24'h0CBC1C, 24'h10ABCD,
    24'h11FF40, 24'h12000E, 24'h130F0F, 24'h143C3C, 24'h150102, 24'h16FFFF, 24'h17AA55,
    24'h187788, 24'h1A5A5A, 24'h1BFFFF, 24'h1C0040, 24'h2D1234, 24'h40591D, 24'h41BB0F,
    24'h50B850};

  soe_exec_unit #(.CHAIN_LEN(3)) dut_u (
    .mclk, .sys_rst, .indexB1, .indexB2, .memReq, .memWrite, .memAddr, .memWdata, .memAck,
    .memRdata, .accumulator, .progAddr, .adderStatusFlipflop, .accumulatorLoadStrobe,
    .addressRegisterLoadStrobe, .jumpTaken, .cycleState, .phaseT00
  );
  soe_mem_model mem_u (.mclk, .sys_rst, .slow, .memReq, .memWrite, .memAddr, .memWdata, .memAck, .memRdata);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [0:15] seen, input logic [0:15] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // kind 0 accumulator load, 1 write answer, 2 jump
  task automatic wait_ev(input int kind);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge mclk);
      #1;
      if (kind == 0 && accumulatorLoadStrobe === 1'b1)
        return;
      if (kind == 1 && (memReq & memWrite & memAck) === 1'b1)
        return;
      if (kind == 2 && jumpTaken === 1'b1)
        return;
    end
    n_errors++;
    tally_and_finish();
  endtask : wait_ev

  task automatic acc_is(input logic [0:15] exp);
    wait_ev(0);
    chk(accumulator, exp);
  endtask : acc_is

  task automatic wr_is(input logic [0:15] a, input logic [0:15] d);
    wait_ev(1);
    chk(memAddr, a);
    chk(memWdata, d);
  endtask : wr_is

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state;
    chk(accumulator, 16'h0000);
    chk(progAddr, 16'h0000);
    chk(16'(memReq), 16'h0001);
  endtask : t_reset_state

  task automatic t_arith;
    acc_is(16'h00CD);
    acc_is(16'h000D);
    chk(16'(adderStatusFlipflop), 16'h0001);
    acc_is(16'hFFFF);
    chk(16'(adderStatusFlipflop), 16'h0000);
    acc_is(16'hF0F0);
    acc_is(16'h3030);
  endtask : t_arith

  task automatic t_replace;
    acc_is(16'h3132);
    wr_is(16'h0015, 16'h3132);
    acc_is(16'h3255);
    wr_is(16'h0017, 16'h3255);
    acc_is(16'h7755);
    wr_is(16'h0018, 16'h7755);
    acc_is(16'h0000);
    chk(16'(adderStatusFlipflop), 16'h0001);
    wr_is(16'h0016, 16'h0000);
  endtask : t_replace

  task automatic t_stores;
    @(posedge mclk);
    slow <= 1'b1;
    acc_is(16'h5A5A);
    wr_is(16'h001A, 16'h0000);
    wr_is(16'h0019, 16'h5A5A);
    wr_is(16'h001B, 16'h0000);
  endtask : t_stores

  task automatic t_jumps;
    wait_ev(2);
    chk(progAddr, 16'h0040);
    acc_is(16'h0034);
    wait_ev(2);
    chk(progAddr, 16'h0050);
    chk(memAddr, 16'h0050);
  endtask : t_jumps

  task automatic t_rerun;
    @(posedge mclk);
    slow    <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    t_reset_state();
    acc_is(16'h00CD);
    acc_is(16'h000D);
  endtask : t_rerun

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst  = 1'b1;
    slow     = 1'b0;
    indexB1  = 16'h0010;
    indexB2  = 16'h0000;
    n_errors = 0;
    n_checks = 0;
    foreach (img[i])
      mem_u.mem[img[i][0:7]] = img[i][8:23];
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    t_reset_state();
    t_arith();
    t_replace();
    t_stores();
    t_jumps();
    t_rerun();
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
